// [tb/serial_tx_model.sv]
// Far side model: remote asynchronous serial transmitter
`timescale 1ns/1ps
module serial_tx_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [8:0]  data_i,
  input  wire logic        nine_i,
  input  wire logic        bad_stop_i,
  input  wire logic        glitch_i,
  input  wire logic        flip_i,
  input  wire logic [15:0] div_i,
  output logic             line_o,
  output logic             busy_o
);
  // ****************************************
  // Frame generation
  // ****************************************
  initial begin
    int bl;
    int tk;
    line_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        bl = 16 * (int'(div_i) + 1);
        tk = int'(div_i) + 1;
        busy_o <= 1'b1;
        // Line driven only from this side, pin is an input
        // Plain digital line, no analog select in the path
        line_o <= 1'b0;
        repeat (glitch_i ? 3 : bl) @(posedge clk_i);
        line_o <= 1'b1;
        // Stay busy until the receiver has re-checked the start bit
        if (glitch_i) begin
          repeat (bl) @(posedge clk_i);
        end
        if (!glitch_i) begin
          for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            line_o <= data_i[i];
            if (flip_i && i == 0) begin
              // One tick wide spike near the centre of the first bit
              repeat (bl / 2) @(posedge clk_i);
              line_o <= ~data_i[0];
              repeat (tk) @(posedge clk_i);
              line_o <= data_i[0];
              repeat (bl / 2 - tk) @(posedge clk_i);
            end else begin
              repeat (bl) @(posedge clk_i);
            end
          end
          line_o <= ~bad_stop_i;
          repeat (bl) @(posedge clk_i);
          line_o <= 1'b1;
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the serial receiver
`timescale 1ns/1ps
module tb_top;
  import rx_pkg::*;
  logic        clk_i;
  logic        rst_i;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  logic        line;
  logic        pend;
  logic        irq;
  logic        go;
  logic        nine;
  logic        bad;
  logic        glitch;
  logic        flip;
  logic        busy;
  logic [8:0]  ch;
  logic [8:0]  chb;
  logic [15:0] div;
  logic [31:0] q;
  logic [31:0] r;
  int          err_total;
  int          cmp_count;

  serial_receiver dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req),
    .wb_o(wb_rsp), .receive_pin_i(line), .receive_pending_o(pend),
    .irq_o(irq));
  serial_tx_model far (.clk_i(clk_i), .go_i(go), .data_i(ch),
    .nine_i(nine), .bad_stop_i(bad), .glitch_i(glitch), .flip_i(flip),
    .div_i(div), .line_o(line), .busy_o(busy));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] exp_char(logic [8:0] c, logic n,
                                           logic fe);
    return {22'h0, fe, n ? c[8] : 1'b0, c[7:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] rq);
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    // Hold the request until ack; a hang ends at the watchdog
    do begin
      @(posedge clk_i);
    end while (wb_rsp.ack !== 1'b1);
    rq = wb_rsp.dat;
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    wb_cycle(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    wb_cycle(1'b0, a, 32'h0, rq);
  endtask

  task automatic send(input logic [8:0] c, input logic n, input logic b,
                      input logic g, input logic f);
    @(posedge clk_i);
    ch <= c;
    nine <= n;
    bad <= b;
    glitch <= g;
    flip <= f;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (busy !== 1'b0);
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // ****************************************
  // Clock, reset and watchdog
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // About six times the expected run of some 6300 cycles
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    logic [7:0] addrs [7];
    addrs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    rst_i = 1'b1;
    wb_req = '0;
    {go, nine, bad, glitch, flip} = '0;
    ch = '0;
    div = 16'h0001;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'h522cceaa));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i], q);
      check(q, 32'h0);
    end
    check(32'(pend), 32'h0);
    check(32'(irq), 32'h0);
    r = $urandom;
    wr(OFS_BAUD, r);
    rd(OFS_BAUD, q);
    check(q, {16'h0, r[15:0]});
    wr(OFS_BAUD, 32'h1);
    // Partial enables and sync mode must not receive
    foreach (addrs[i]) begin
      if (i < 3) begin
        wr(OFS_CTRL, i == 0 ? 32'h2 : (i == 1 ? 32'h1 : 32'h7));
        send(9'($urandom), 1'b0, 1'b0, 1'b0, 1'b0);
        rd(OFS_EVENT, q);
        check(q, 32'h0);
      end
    end
    wr(OFS_CTRL, 32'h3);
    repeat (4) begin
      r = $urandom;
      send({1'b0, r[7:0]}, 1'b0, 1'b0, 1'b0, r[8]);
      check(32'(pend), 32'h1);
      rd(OFS_DATA, q);
      check(q, exp_char({1'b0, r[7:0]}, 1'b0, 1'b0));
      check(32'(pend), 32'h0);
    end
    rd(OFS_EVENT, q);
    send(9'h0ff, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFS_EVENT, q);
    check(q, 32'h0);
    rd(OFS_STATUS, q);
    check(q, 32'h0);
    send(9'h0a5, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(OFS_DATA, q);
    check(q, exp_char(9'h0a5, 1'b0, 1'b0));
    send(9'h081, 1'b0, 1'b1, 1'b0, 1'b0);
    rd(OFS_EVENT, q);
    check(q, 32'h3);
    rd(OFS_STATUS, q);
    check(q, 32'h3);
    rd(OFS_DATA, q);
    check(q, exp_char(9'h081, 1'b0, 1'b1));
    // Two entries fit, the third overruns
    r = $urandom;
    chb = 9'($urandom);
    send({1'b0, r[7:0]}, 1'b0, 1'b0, 1'b0, 1'b0);
    send({1'b0, chb[7:0]}, 1'b0, 1'b0, 1'b0, 1'b0);
    send(9'h055, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(OFS_STATUS, q);
    check(q, 32'h5);
    rd(OFS_DATA, q);
    check(q, exp_char({1'b0, r[7:0]}, 1'b0, 1'b0));
    rd(OFS_DATA, q);
    check(q, exp_char({1'b0, chb[7:0]}, 1'b0, 1'b0));
    rd(OFS_DATA, q);
    check(q, 32'h0);
    send(9'h03c, 1'b0, 1'b0, 1'b0, 1'b0);
    check(32'(pend), 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h3);
    send(9'h0c3, 1'b0, 1'b0, 1'b0, 1'b0);
    wr(OFS_STATUS, 32'h0);
    wr(OFS_DATA, 32'h0);
    check(32'(pend), 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL, 32'h3 | (i << 4));
      check(32'(pend), 32'h1);
      check(32'(irq), (i == 7) ? 32'h1 : 32'h0);
    end
    rd(OFS_DATA, q);
    check(q, exp_char(9'h0c3, 1'b0, 1'b0));
    rd(OFS_EVENT, q);
    wr(OFS_MASK, 32'h1);
    wr(OFS_CTRL, 32'h63);
    check(32'(irq), 32'h0);
    send(9'h011, 1'b0, 1'b0, 1'b0, 1'b0);
    check(32'(irq), 32'h1);
    rd(OFS_EVENT, q);
    check(q, 32'h1);
    check(32'(irq), 32'h0);
    rd(OFS_DATA, q);
    wr(OFS_CTRL, 32'hb);
    repeat (3) begin
      r = $urandom;
      send(r[8:0], 1'b1, 1'b0, 1'b0, r[9]);
      rd(OFS_DATA, q);
      check(q, exp_char(r[8:0], 1'b1, 1'b0));
    end
    stop_test();
  end
endmodule

// [verilog/rx_fifo.sv]
// Receive character FIFO
`timescale 1ns/1ps
module rx_fifo #(
  parameter int unsigned DEPTH = rx_pkg::FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             push_i,
  input  rx_pkg::rx_char_t      data_i,
  input  wire logic             pop_i,
  output rx_pkg::rx_char_t      head_o,
  output logic                  empty_o,
  output logic                  full_o
);
  import rx_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    rx_char_t [DEPTH-1:0] mem;
    logic     [PW-1:0]    wptr;
    logic     [PW-1:0]    rptr;
    logic     [CW-1:0]    count;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic        do_push;
  logic        do_pop;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return p + PW'(1);
  endfunction

  assign empty_o = (s_reg.count == '0);
  assign full_o  = (s_reg.count == CW'(DEPTH));
  assign head_o  = s_reg.mem[s_reg.rptr];   // Oldest entry
  assign do_push = push_i & ~full_o;
  assign do_pop  = pop_i & ~empty_o;

  always_comb begin
    s_next = s_reg;
    if (do_push) begin
      s_next.mem[s_reg.wptr] = data_i;
      s_next.wptr            = ptr_inc(s_reg.wptr);
    end
    if (do_pop) begin
      s_next.rptr = ptr_inc(s_reg.rptr);
    end
    s_next.count = s_reg.count + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_fifo_pop_count: assert property (
    do_pop && !do_push |=> s_reg.count == $past(s_reg.count) - CW'(1))
    else $error("fifo pop did not remove an entry");
  a_fifo_push_lands: assert property (
    do_push && !do_pop |=>
    !empty_o && s_reg.count == $past(s_reg.count) + CW'(1))
    else $error("fifo push did not store an entry");

endmodule

// [verilog/rx_pkg.sv]
// Constants, register map and shared types of the serial receiver
package rx_pkg;

  // ****************************************
  // Sampling
  // ****************************************
  localparam int unsigned OVERSAMPLE      = 16;
  localparam logic [3:0]  OS_FIRST_SAMPLE = 4'h6;
  localparam logic [3:0]  OS_DECIDE       = 4'h8;
  localparam logic [3:0]  BITS_EIGHT      = 4'h8;
  localparam logic [3:0]  BITS_NINE       = 4'h9;
  localparam int unsigned FIFO_DEPTH      = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_BAUD   = 8'h04;
  localparam logic [7:0]  OFS_STATUS = 8'h08;
  localparam logic [7:0]  OFS_DATA   = 8'h0c;
  localparam logic [7:0]  OFS_EVENT  = 8'h10;
  localparam logic [7:0]  OFS_MASK   = 8'h14;

  localparam int unsigned CTRL_SERIAL_PORT_ENABLE          = 0;
  localparam int unsigned CTRL_CONTINUOUS_RECEIVE_ENABLE   = 1;
  localparam int unsigned CTRL_SYNC                        = 2;
  localparam int unsigned CTRL_NINE                        = 3;
  localparam int unsigned CTRL_RECEIVE_INTERRUPT_ENABLE    = 4;
  localparam int unsigned CTRL_PERIPHERAL_INTERRUPT_ENABLE = 5;
  localparam int unsigned CTRL_GLOBAL_INTERRUPT_ENABLE     = 6;
  localparam int unsigned CTRL_W                           = 7;

  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_FERR = 1;
  localparam int unsigned STAT_OERR = 2;
  localparam int unsigned STAT_BUSY = 3;

  localparam int unsigned EVT_CHAR = 0;
  localparam int unsigned EVT_FERR = 1;
  localparam int unsigned EVT_OVR  = 2;
  localparam int unsigned EVT_W    = 3;

  localparam logic [6:0]  CTRL_RESET = 7'h00;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  localparam logic [2:0]  MASK_RESET = 3'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       frame_err;
    logic [8:0] data;
  } rx_char_t;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0]       dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage

// [verilog/serial_receiver.sv]
// Asynchronous serial receiver with Wishbone register access
`timescale 1ns/1ps
module serial_receiver (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  rx_pkg::wb_req_t wb_i,
  output rx_pkg::wb_rsp_t wb_o,
  input  wire logic      receive_pin_i,
  output logic           receive_pending_o,
  output logic           irq_o
);
  import rx_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rx_state_t         st;
    logic [15:0]       div_cnt;
    logic [3:0]        os_cnt;
    logic [3:0]        bit_cnt;
    logic [8:0]        receive_shift_register;
    logic [2:0]        smp;
    logic              rx_prev;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       baud;
    logic [EVT_W-1:0]  evt;
    logic [EVT_W-1:0]  mask;
    logic              overrun;
    logic              ack;
    logic [31:0]       rdata;
    logic              push;
    rx_char_t          push_char;
  } rx_main_state_t;

  rx_main_state_t s_reg;
  rx_main_state_t s_next;

  rx_char_t         fifo_head;
  logic             fifo_empty;
  logic             fifo_full;
  logic             pop;
  logic             rx_enabled;
  logic             tick;
  logic             decide;
  logic             maj;
  logic             access;
  logic             stop_store;
  logic [3:0]       nbits;
  logic [EVT_W-1:0] new_evt;

  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Character FIFO
  // ****************************************
  rx_fifo #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .push_i  (s_reg.push),
    .data_i  (s_reg.push_char),
    .pop_i   (pop),
    .head_o  (fifo_head),
    .empty_o (fifo_empty),
    .full_o  (fifo_full)
  );

  // ****************************************
  // Decoded terms
  // ****************************************
  assign rx_enabled = s_reg.ctrl[CTRL_CONTINUOUS_RECEIVE_ENABLE] &
                      ~s_reg.ctrl[CTRL_SYNC] &
                      s_reg.ctrl[CTRL_SERIAL_PORT_ENABLE];
  assign tick       = (s_reg.div_cnt == 16'h0000);
  assign decide     = tick & (s_reg.os_cnt == OS_DECIDE);
  assign maj        = maj3({s_reg.smp[1:0], receive_pin_i});
  assign nbits      = s_reg.ctrl[CTRL_NINE] ? BITS_NINE : BITS_EIGHT;
  assign access     = wb_i.cyc & wb_i.stb & ~s_reg.ack;
  assign pop        = access & ~wb_i.we & (wb_i.adr == OFS_DATA) &
                      ~fifo_empty;
  assign stop_store = (s_reg.st == RX_STOP) & decide &
                      ~(fifo_full & ~pop);

  // Pending flag depends on FIFO contents and the port enable, receive enable and sync controls only
  assign receive_pending_o = rx_enabled & ~fifo_empty;

  // Interrupt gated by the enables
  assign irq_o = s_reg.ctrl[CTRL_GLOBAL_INTERRUPT_ENABLE] &
                 s_reg.ctrl[CTRL_PERIPHERAL_INTERRUPT_ENABLE] &
                 ((s_reg.ctrl[CTRL_RECEIVE_INTERRUPT_ENABLE] &
                   receive_pending_o) |
                  (|(s_reg.evt & s_reg.mask)));

  assign wb_o.ack = s_reg.ack;
  assign wb_o.dat = s_reg.rdata;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next         = s_reg;
    new_evt        = '0;
    s_next.push    = 1'b0;
    s_next.rx_prev = receive_pin_i;

    // Baud tick divider, one tick per sixteenth of a bit
    if (tick) begin
      s_next.div_cnt = s_reg.baud;
    end else begin
      s_next.div_cnt = s_reg.div_cnt - 16'h0001;
    end

    if (tick && s_reg.st != RX_IDLE) begin
      s_next.os_cnt = s_reg.os_cnt + 4'h1;
      if (s_reg.os_cnt >= OS_FIRST_SAMPLE &&
          s_reg.os_cnt <= OS_DECIDE) begin
        s_next.smp = {s_reg.smp[1:0], receive_pin_i};
      end
    end

    case (s_reg.st)
      RX_IDLE: begin
        s_next.os_cnt = 4'h0;
        // Overrun holds the receiver here
        if (rx_enabled && !s_reg.overrun &&
            s_reg.rx_prev && !receive_pin_i) begin
          s_next.st      = RX_START;
          s_next.div_cnt = s_reg.baud;
        end
      end
      RX_START: begin
        if (decide) begin
          s_next.bit_cnt = 4'h0;
          if (maj) begin
            s_next.st = RX_IDLE;
          end else begin
            s_next.st = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (decide) begin
          s_next.receive_shift_register =
            {maj, s_reg.receive_shift_register[8:1]};
          s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          if (s_reg.bit_cnt + 4'h1 == nbits) begin
            s_next.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (decide) begin
          s_next.st = RX_IDLE;
          s_next.push_char.frame_err = ~maj;
          if (s_reg.ctrl[CTRL_NINE]) begin
            s_next.push_char.data = s_reg.receive_shift_register;
          end else begin
            s_next.push_char.data =
              {1'b0, s_reg.receive_shift_register[8:1]};
          end
          new_evt[EVT_CHAR] = 1'b1;
          new_evt[EVT_FERR] = ~maj;
          if (stop_store) begin
            s_next.push = 1'b1;
          end else begin
            s_next.overrun    = 1'b1;
            new_evt[EVT_OVR]  = 1'b1;
          end
        end
      end
      default: begin
        s_next.st = RX_IDLE;
      end
    endcase

    if (!rx_enabled) begin
      s_next.st = RX_IDLE;
    end
    // Clearing continuous receive clears the overrun
    if (!s_reg.ctrl[CTRL_CONTINUOUS_RECEIVE_ENABLE]) begin
      s_next.overrun = 1'b0;
    end

    // Bus slave, answer one cycle after the request
    s_next.ack = access;
    if (access) begin
      s_next.rdata = 32'h0000_0000;
      if (wb_i.we) begin
        // Data and status writes are dropped
        case (wb_i.adr)
          OFS_CTRL: begin
            s_next.ctrl = CTRL_W'(put_byte(32'(s_reg.ctrl), wb_i.dat,
                                           wb_i.sel));
          end
          OFS_BAUD: begin
            s_next.baud = 16'(put_byte(32'(s_reg.baud), wb_i.dat,
                                       wb_i.sel));
          end
          OFS_MASK: begin
            s_next.mask = EVT_W'(put_byte(32'(s_reg.mask), wb_i.dat,
                                          wb_i.sel));
          end
          default: begin
            s_next.rdata = 32'h0000_0000;
          end
        endcase
      end else begin
        case (wb_i.adr)
          OFS_CTRL:   s_next.rdata = 32'(s_reg.ctrl);
          OFS_BAUD:   s_next.rdata = 32'(s_reg.baud);
          OFS_STATUS: begin
            s_next.rdata[STAT_PEND] = receive_pending_o;
            s_next.rdata[STAT_FERR] = ~fifo_empty & fifo_head.frame_err;
            s_next.rdata[STAT_OERR] = s_reg.overrun;
            s_next.rdata[STAT_BUSY] = (s_reg.st != RX_IDLE);
          end
          OFS_DATA: begin
            if (!fifo_empty) begin
              s_next.rdata = 32'(fifo_head);
            end
          end
          OFS_EVENT:  s_next.rdata = 32'(s_reg.evt);
          OFS_MASK:   s_next.rdata = 32'(s_reg.mask);
          default:    s_next.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Event bits: read clears, a new event wins over the clear
    if (access && !wb_i.we && wb_i.adr == OFS_EVENT) begin
      s_next.evt = new_evt;
    end else begin
      s_next.evt = s_reg.evt | new_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.ctrl <= CTRL_RESET;
      s_reg.baud <= BAUD_RESET;
      s_reg.mask <= MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pending_after_stop: assert property (
    stop_store && rx_enabled ##1 rx_enabled |=> receive_pending_o)
    else $error("pending flag not raised after a stored character");
  a_irq_needs_enables: assert property (irq_o |->
    s_reg.ctrl[CTRL_GLOBAL_INTERRUPT_ENABLE] &&
    s_reg.ctrl[CTRL_PERIPHERAL_INTERRUPT_ENABLE])
    else $error("interrupt raised without global and peripheral enable");
  a_pending_ignores_enables: assert property (
    rx_enabled && !fifo_empty &&
    !s_reg.ctrl[CTRL_RECEIVE_INTERRUPT_ENABLE] |-> receive_pending_o)
    else $error("pending flag gated by interrupt enable");
  a_ack_single_pulse: assert property (
    $rose(s_reg.ack) |=> !s_reg.ack)
    else $error("bus acknowledge longer than one cycle");
  a_overrun_holds_idle: assert property (
    s_reg.overrun |-> s_reg.st == RX_IDLE && !s_reg.push)
    else $error("receiver active while overrun is set");
  a_false_start_quiet: assert property (
    s_reg.st == RX_START && decide && maj |=>
    s_reg.st == RX_IDLE ##1 !s_reg.push)
    else $error("false start not abandoned quietly");
  a_stop_low_ferr: assert property (
    stop_store && !maj |=> s_reg.push && s_reg.push_char.frame_err)
    else $error("low stop bit without framing error");
  a_disabled_goes_idle: assert property (
    !rx_enabled |=> s_reg.st == RX_IDLE)
    else $error("receiver busy while disabled");
  a_stop_after_nbits: assert property (
    s_reg.st == RX_DATA && s_next.st == RX_STOP |->
    s_reg.bit_cnt + 4'h1 == nbits)
    else $error("stop bit reached with wrong bit count");
  a_shift_per_bit: assert property (
    s_reg.st == RX_DATA && !decide |=> $stable(s_reg.bit_cnt))
    else $error("shift register advanced off the bit center");

  c_char_stored:  cover property (stop_store && maj);
  c_frame_error:  cover property (stop_store && !maj);
  c_overrun:      cover property ($rose(s_reg.overrun));
  c_false_start:  cover property (s_reg.st == RX_START && decide && maj);

endmodule
